/* File: hdl/rmc_pkg.sv */
// Constants for the maker configuration register bank
package rmc_pkg;
	// ----------------------------------------------------------------
	// Command codes
	// ----------------------------------------------------------------
	localparam logic [7:0] RMC_CMD_LOCK_RESET = 8'hD0;
	localparam logic [7:0] RMC_CMD_MAKER_CFG = 8'hD1;
	localparam logic [7:0] RMC_CMD_REG_CFG_A = 8'hD2;
	// ----------------------------------------------------------------
	// Reset values and writable masks
	// ----------------------------------------------------------------
	localparam logic [7:0] RMC_LOCK_RESET_RST = 8'h00;
	localparam logic [7:0] RMC_MAKER_CFG_RST = 8'h07;
	localparam logic [7:0] RMC_REG_CFG_A_RST = 8'h52;
	localparam logic [7:0] RMC_MAKER_CFG_MASK = 8'hCF;
	localparam logic [7:0] RMC_REG_CFG_A_MASK = 8'h7E;
	localparam logic [7:0] RMC_UNMAPPED_DATA = 8'h00;
	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int RMC_LOCK_BIT = 0;
	localparam int RMC_SOFT_RESET_BIT = 1;
	localparam int RMC_RPC_MSB = 7;
	localparam int RMC_RPC_LSB = 6;
	localparam int RMC_TIMEOUT_EN_BIT = 3;
	localparam int RMC_FAULT_EN_BIT = 2;
	localparam int RMC_ALERT_EN_BIT = 1;
	localparam int RMC_MONITOR_EN_BIT = 0;
	localparam int RMC_PHASE_MSB = 6;
	localparam int RMC_PHASE_LSB = 4;
	localparam int RMC_VSRC_BIT = 3;
	localparam int RMC_LOOP_EN_BIT = 2;
	localparam int RMC_CLIM_EN_BIT = 1;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int RMC_CLK_MHZ = 100;
	localparam int RMC_LINK_TIMEOUT_MS = 35;
	localparam int RMC_LINK_TIMEOUT_CYCLES = RMC_LINK_TIMEOUT_MS * 1000 * RMC_CLK_MHZ;
	localparam int RMC_TO_CNT_W = 22;
endpackage

/* File: hdl/rmc_bank.sv */
// Maker configuration register bank with lock and soft reset
`timescale 1ns/1ps
module rmc_bank import rmc_pkg::*; #(
	parameter int TIMEOUT_CYCLES = RMC_LINK_TIMEOUT_CYCLES
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire logic i_wr_stb,
	input wire logic i_rd_stb,
	input wire logic [7:0] i_cmd,
	input wire logic [7:0] i_wr_data,
	output logic [7:0] o_rd_data,
	output logic o_rd_valid,
	input wire logic i_in_transaction,
	input wire logic i_bus_activity,
	output logic o_bus_release,
	input wire logic i_fault_raw,
	input wire logic i_alert_raw,
	output logic o_fault_pin,
	output logic o_alert_pin,
	output logic o_monitor_enable,
	output logic [1:0] o_reduced_phase_count,
	output logic [2:0] o_phase_count,
	input wire logic [7:0] i_vout_command,
	input wire logic [7:0] i_vid_pins,
	output logic [7:0] o_vout_target,
	output logic o_current_limit_enable,
	input wire logic i_pair_loop_enable,
	output logic o_loop_test_enable
);
	// ----------------------------------------------------------------
	// Decode functions
	// ----------------------------------------------------------------
	function automatic logic [1:0] rpc_decode(input logic [1:0] code);
		rpc_decode = (code == 2'b01) ? 2'd2 : (code == 2'b10) ? 2'd3 : 2'd1;
	endfunction

	function automatic logic [2:0] phase_decode(input logic [2:0] code);
		phase_decode = (code <= 3'd5) ? code + 3'd1 : 3'd6;
	endfunction

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	logic lock_q, lock_d;
	logic [7:0] mcfg_q, mcfg_d;
	logic [7:0] vcfg_q, vcfg_d;
	logic [7:0] rd_data_q, rd_data_d;
	logic rd_valid_q, rd_valid_d;

	// Next values for writes, soft reset and lock
	always_comb begin
		lock_d = lock_q;
		mcfg_d = mcfg_q;
		vcfg_d = vcfg_q;
		if (i_wr_stb && !lock_q) begin
			if (i_cmd == RMC_CMD_LOCK_RESET) begin
				if (i_wr_data[RMC_SOFT_RESET_BIT]) begin
					mcfg_d = RMC_MAKER_CFG_RST;
					vcfg_d = RMC_REG_CFG_A_RST;
				end
				lock_d = i_wr_data[RMC_LOCK_BIT];
			end else if (i_cmd == RMC_CMD_MAKER_CFG) begin
				mcfg_d = i_wr_data & RMC_MAKER_CFG_MASK;
			end else if (i_cmd == RMC_CMD_REG_CFG_A) begin
				vcfg_d = i_wr_data & RMC_REG_CFG_A_MASK;
			end
		end
	end

	// Read mux, soft reset bit never stored
	always_comb begin
		rd_valid_d = i_rd_stb;
		rd_data_d = rd_data_q;
		if (i_rd_stb) begin
			if (i_cmd == RMC_CMD_LOCK_RESET) begin
				rd_data_d = {7'h00, lock_q};
			end else if (i_cmd == RMC_CMD_MAKER_CFG) begin
				rd_data_d = mcfg_q;
			end else if (i_cmd == RMC_CMD_REG_CFG_A) begin
				rd_data_d = vcfg_q;
			end else begin
				rd_data_d = RMC_UNMAPPED_DATA;
			end
		end
	end

	// Register stage; only power-on reset clears the lock
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			lock_q <= RMC_LOCK_RESET_RST[RMC_LOCK_BIT];
			mcfg_q <= RMC_MAKER_CFG_RST;
			vcfg_q <= RMC_REG_CFG_A_RST;
			rd_data_q <= RMC_UNMAPPED_DATA;
			rd_valid_q <= 1'b0;
		end else begin
			lock_q <= lock_d;
			mcfg_q <= mcfg_d;
			vcfg_q <= vcfg_d;
			rd_data_q <= rd_data_d;
			rd_valid_q <= rd_valid_d;
		end
	end

	assign o_rd_data = rd_data_q;
	assign o_rd_valid = rd_valid_q;

	// ----------------------------------------------------------------
	// Link timeout
	// ----------------------------------------------------------------
	logic [RMC_TO_CNT_W-1:0] to_cnt_q, to_cnt_d;
	logic release_q, release_d;

	// Count idle cycles inside a transaction
	always_comb begin
		to_cnt_d = '0;
		release_d = 1'b0;
		if (mcfg_q[RMC_TIMEOUT_EN_BIT] && i_in_transaction && !i_bus_activity) begin
			if (to_cnt_q >= RMC_TO_CNT_W'(TIMEOUT_CYCLES)) begin
				release_d = 1'b1;
			end else begin
				to_cnt_d = to_cnt_q + 1'b1;
			end
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			to_cnt_q <= '0;
			release_q <= 1'b0;
		end else begin
			to_cnt_q <= to_cnt_d;
			release_q <= release_d;
		end
	end

	assign o_bus_release = release_q;

	// ----------------------------------------------------------------
	// Voltage source select and pin synchroniser
	// ----------------------------------------------------------------
	logic [7:0] vid_meta_q, vid_sync_q, vout_q, vout_d;

	// Pick command code or synchronised pins
	always_comb begin
		vout_d = vcfg_q[RMC_VSRC_BIT] ? i_vout_command : vid_sync_q;
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_b) begin
			vid_meta_q <= 8'h00;
			vid_sync_q <= 8'h00;
			vout_q <= 8'h00;
		end else begin
			vid_meta_q <= i_vid_pins;
			vid_sync_q <= vid_meta_q;
			vout_q <= vout_d;
		end
	end

	assign o_vout_target = vout_q;

	// ----------------------------------------------------------------
	// Configuration outputs
	// ----------------------------------------------------------------
	assign o_fault_pin = i_fault_raw & mcfg_q[RMC_FAULT_EN_BIT];
	assign o_alert_pin = i_alert_raw & mcfg_q[RMC_ALERT_EN_BIT];
	assign o_monitor_enable = mcfg_q[RMC_MONITOR_EN_BIT];
	assign o_reduced_phase_count = rpc_decode(mcfg_q[RMC_RPC_MSB:RMC_RPC_LSB]);
	assign o_phase_count = phase_decode(vcfg_q[RMC_PHASE_MSB:RMC_PHASE_LSB]);
	assign o_current_limit_enable = vcfg_q[RMC_CLIM_EN_BIT];
	assign o_loop_test_enable = vcfg_q[RMC_LOOP_EN_BIT] & i_pair_loop_enable;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_b);

	sequence s_reset_write;
		i_wr_stb && i_cmd == RMC_CMD_LOCK_RESET && i_wr_data[RMC_SOFT_RESET_BIT];
	endsequence
	sequence s_defaults;
		mcfg_q == RMC_MAKER_CFG_RST && vcfg_q == RMC_REG_CFG_A_RST;
	endsequence

	property p_soft_reset;
		(!lock_q ##0 s_reset_write) |=> s_defaults;
	endproperty
	a_soft_reset: assert property (p_soft_reset) else $error("soft reset missed");

	property p_reset_locked;
		(lock_q ##0 s_reset_write) |=> ($stable(mcfg_q) && $stable(vcfg_q) && lock_q);
	endproperty
	a_reset_locked: assert property (p_reset_locked) else $error("reset acted while locked");

	property p_lock_sticky;
		lock_q |=> lock_q [*8];
	endproperty
	a_lock_sticky: assert property (p_lock_sticky) else $error("lock cleared");

	property p_frozen;
		lock_q && i_wr_stb |=> $stable(mcfg_q[RMC_TIMEOUT_EN_BIT]) && $stable(vcfg_q);
	endproperty
	a_frozen: assert property (p_frozen) else $error("locked register changed");

	property p_rpc;
		mcfg_q[RMC_RPC_MSB:RMC_RPC_LSB] == 2'b11 |-> o_reduced_phase_count == 2'd1;
	endproperty
	a_rpc: assert property (p_rpc) else $error("reduced phase count wrong");

	property p_release;
		o_bus_release |-> $past(mcfg_q[RMC_TIMEOUT_EN_BIT]) && $past(to_cnt_q) >= RMC_TO_CNT_W'(TIMEOUT_CYCLES);
	endproperty
	a_release: assert property (p_release) else $error("early bus release");

	property p_fault_gate;
		!mcfg_q[RMC_FAULT_EN_BIT] |-> !o_fault_pin;
	endproperty
	a_fault_gate: assert property (p_fault_gate) else $error("fault driven while disabled");

	property p_alert_gate;
		!mcfg_q[RMC_ALERT_EN_BIT] |-> !o_alert_pin;
	endproperty
	a_alert_gate: assert property (p_alert_gate) else $error("alert driven while disabled");

	property p_monitor;
		(i_wr_stb && !lock_q && i_cmd == RMC_CMD_MAKER_CFG) |=> o_monitor_enable == $past(i_wr_data[RMC_MONITOR_EN_BIT]);
	endproperty
	a_monitor: assert property (p_monitor) else $error("monitor enable not updated");

	property p_phase;
		vcfg_q[RMC_PHASE_MSB:RMC_PHASE_LSB] >= 3'd5 |-> o_phase_count == 3'd6;
	endproperty
	a_phase: assert property (p_phase) else $error("phase count wrong");

	property p_vsrc;
		$past(vcfg_q[RMC_VSRC_BIT]) |-> o_vout_target == $past(i_vout_command);
	endproperty
	a_vsrc: assert property (p_vsrc) else $error("target not from command code");

	property p_loop;
		!i_pair_loop_enable |-> !o_loop_test_enable;
	endproperty
	a_loop: assert property (p_loop) else $error("loop test without pair");

	property p_self_clear;
		i_rd_stb && i_cmd == RMC_CMD_LOCK_RESET |=> o_rd_valid && !o_rd_data[RMC_SOFT_RESET_BIT];
	endproperty
	a_self_clear: assert property (p_self_clear) else $error("reset bit read back set");
endmodule

/* File: sim/rmc_host.sv */
// Host model issuing command-coded register accesses
`timescale 1ns/1ps
module rmc_host (
	input wire logic i_ref_clk,
	input wire logic i_rd_valid,
	input wire logic [7:0] i_rd_data,
	output logic o_wr_stb,
	output logic o_rd_stb,
	output logic [7:0] o_cmd,
	output logic [7:0] o_wr_data
);
	// Idle strobes, junk on the fields
	initial begin
		o_wr_stb = 1'b0;
		o_rd_stb = 1'b0;
		o_cmd = 8'h5a;
		o_wr_data = 8'ha5;
	end
	// One-cycle write pulse, fields scrambled after
	task automatic wr(input logic [7:0] cmd, input logic [7:0] data);
		@(negedge i_ref_clk);
		o_cmd = cmd;
		o_wr_data = data;
		o_wr_stb = 1'b1;
		@(negedge i_ref_clk);
		o_wr_stb = 1'b0;
		o_cmd = ~cmd;
		o_wr_data = ~data;
	endtask
	// Read pulse, then bounded wait for the answer
	task automatic rd(input logic [7:0] cmd, output logic [7:0] data, output logic ok);
		@(negedge i_ref_clk);
		o_cmd = cmd;
		o_rd_stb = 1'b1;
		@(negedge i_ref_clk);
		o_rd_stb = 1'b0;
		o_cmd = ~cmd;
		ok = 1'b0;
		data = 8'h00;
		for (int n = 0; n < 4 && ok !== 1'b1; n++) begin
			if (i_rd_valid === 1'b1) begin
				ok = 1'b1;
				data = i_rd_data;
			end else begin
				@(negedge i_ref_clk);
			end
		end
	endtask
endmodule

/* File: sim/testbench.sv */
// Self-checking bench for the maker configuration register bank
`timescale 1ns/1ps
module testbench;
	import rmc_pkg::*;
	localparam int TO = 8;
	localparam logic [7:0] LR = RMC_CMD_LOCK_RESET;
	localparam logic [7:0] MC = RMC_CMD_MAKER_CFG;
	localparam logic [7:0] RA = RMC_CMD_REG_CFG_A;
	logic i_ref_clk, i_rst_b, wr, rd, valid, in_tr, act, rel, flt, alr, mon, clim, pair, loop, ok;
	logic fraw, araw;
	logic [7:0] cmd, wdat, rdat, vout, got;
	logic [1:0] rpc;
	logic [2:0] ph;
	int fails, checks, n;
	// Clock at 100 MHz
	initial begin
		i_ref_clk = 1'b0;
		forever #5 i_ref_clk = ~i_ref_clk;
	end
	rmc_host i_host (.i_ref_clk(i_ref_clk), .i_rd_valid(valid), .i_rd_data(rdat), .o_wr_stb(wr),
		.o_rd_stb(rd), .o_cmd(cmd), .o_wr_data(wdat));
	rmc_bank #(.TIMEOUT_CYCLES(TO)) i_dut (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_wr_stb(wr),
		.i_rd_stb(rd), .i_cmd(cmd), .i_wr_data(wdat), .o_rd_data(rdat), .o_rd_valid(valid),
		.i_in_transaction(in_tr), .i_bus_activity(act), .o_bus_release(rel), .i_fault_raw(fraw),
		.i_alert_raw(araw), .o_fault_pin(flt), .o_alert_pin(alr), .o_monitor_enable(mon),
		.o_reduced_phase_count(rpc), .o_phase_count(ph), .i_vout_command(8'h3c), .i_vid_pins(8'hc3),
		.o_vout_target(vout), .o_current_limit_enable(clim), .i_pair_loop_enable(pair),
		.o_loop_test_enable(loop));
	// ----------------------------------------
	// Compare and report helpers
	// ----------------------------------------
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		checks++;
		if (g !== e) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic rchk(input logic [7:0] c, input logic [7:0] e);
		i_host.rd(c, got, ok);
		chk({7'h00, ok}, 8'h01);
		chk(got, e);
	endtask
	// Count idle cycles until release, bounded
	task automatic idle_wait(input int lim);
		n = 0;
		while (n < lim && rel !== 1'b1) begin
			@(negedge i_ref_clk);
			n++;
		end
	endtask
	task automatic results;
		if (fails == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Main sequence
	initial begin
		fails = 0;
		checks = 0;
		i_rst_b = 1'b0;
		in_tr = 1'b0;
		act = 1'b0;
		pair = 1'b1;
		fraw = 1'b1;
		araw = 1'b1;
		repeat (12) @(negedge i_ref_clk);
		i_rst_b = 1'b1;
		rchk(LR, 8'h00);
		rchk(MC, 8'h07);
		rchk(RA, 8'h52);
		chk({6'h00, rpc}, 8'h01);
		chk({5'h00, ph}, 8'h06);
		chk({6'h00, flt, mon}, 8'h03);
		fraw = 1'b0;
		araw = 1'b0;
		@(negedge i_ref_clk);
		chk({6'h00, alr, flt}, 8'h00);
		fraw = 1'b1;
		araw = 1'b1;
		rchk(8'hd3, 8'h00);
		for (int c = 0; c < 4; c++) begin
			i_host.wr(MC, {c[1:0], 6'h3f});
			rchk(MC, {c[1:0], 6'h0f});
			chk({6'h00, rpc}, (c == 2) ? 8'h03 : (c == 1) ? 8'h02 : 8'h01);
			chk({6'h00, alr, flt}, 8'h03);
		end
		for (int c = 0; c < 8; c++) begin
			i_host.wr(RA, {1'b1, c[2:0], 4'hf});
			rchk(RA, {1'b0, c[2:0], 4'he});
			chk({5'h00, ph}, (c > 5) ? 8'h06 : 8'(c + 1));
			chk({6'h00, loop, clim}, 8'h03);
		end
		chk(vout, 8'h3c);
		pair = 1'b0;
		#1 chk({7'h00, loop}, 8'h00);
		i_host.wr(MC, 8'h00);
		i_host.wr(RA, 8'h00);
		pair = 1'b1;
		repeat (4) @(negedge i_ref_clk);
		chk({4'h0, alr, flt, mon, loop}, 8'h00);
		chk(vout, 8'hc3);
		in_tr = 1'b1;
		idle_wait(3 * TO);
		chk(8'(n), 8'(3 * TO));
		i_host.wr(MC, 8'h08);
		idle_wait(3 * TO);
		chk({7'h00, n > TO && n <= TO + 3}, 8'h01);
		// Activity every fourth cycle keeps the idle count short
		n = 0;
		for (int k = 0; k < 3 * TO; k++) begin
			act = (k % 4 == 0);
			@(negedge i_ref_clk);
			if (rel !== 1'b0)
				n++;
		end
		act = 1'b0;
		chk(8'(n), 8'h00);
		in_tr = 1'b0;
		i_host.wr(LR, 8'h02);
		rchk(MC, 8'h07);
		rchk(RA, 8'h52);
		rchk(LR, 8'h00);
		i_host.wr(MC, 8'hc0);
		i_host.wr(LR, 8'h01);
		i_host.wr(LR, 8'h02);
		i_host.wr(MC, 8'h08);
		rchk(MC, 8'hc0);
		rchk(LR, 8'h01);
		// Power cycle is the only way out of lock
		i_rst_b = 1'b0;
		repeat (3) @(negedge i_ref_clk);
		i_rst_b = 1'b1;
		rchk(LR, 8'h00);
		rchk(MC, 8'h07);
		results();
	end
endmodule
